// File: hw/gfs_regs.sv
`default_nettype none

module gfs_regs #(
    parameter int unsigned TICK_CYCLES = gfs_pkg::TICK_CYCLES
) (
    // Clock and reset.
    input wire logic SYS_CLK,
    input wire logic RSTN,
    // Register port.
    input wire logic [15:0] REG_ADDR,
    input wire logic [15:0] REG_WDATA,
    input wire logic REG_WR,
    input wire logic REG_RD,
    output logic [15:0] REG_RDATA,
    // Gauge core.
    input wire logic GAUGE_DONE,
    input wire logic GAUGE_RESTING,
    output logic ITER_START,
    output logic REST_HEAVY,
    output logic ALG_RESET,
    output logic LOG_CLEARING,
    output logic CONFIG_MODE,
    output logic LEARN_BKUP_MODE,
    output gfs_pkg::gfs_settings_type SETTINGS,
    // Interrupt.
    output logic IRQ
);

    typedef struct packed {
        logic [gfs_pkg::TICK_W-1:0] tick_cnt;
        logic [7:0] ivl_cnt;
        logic [4:0] rest_cnt;
        gfs_pkg::gfs_settings_type set;
        logic [15:0] flags;
        logic [gfs_pkg::NUM_EV-1:0] irq_st;
        logic [gfs_pkg::NUM_EV-1:0] irq_en;
        logic [15:0] rdata;
        logic iter_start;
        logic rest_heavy;
        logic alg_rst;
        logic irq;
    } gfs_state_type;

    localparam int TW = gfs_pkg::TICK_W;
    localparam logic [TW-1:0] TICK_LAST = TW'(TICK_CYCLES - 1);

    gfs_state_type s_r;
    gfs_state_type s_nxt;

    // -------------------------------------------------------------------------
    // Helpers.
    // -------------------------------------------------------------------------
    function automatic logic [15:0] clamp(input logic [15:0] v, input logic [15:0] lo,
                                          input logic [15:0] hi);
        clamp = (v < lo) ? lo : ((v > hi) ? hi : v);
    endfunction : clamp

    // Rest multiple, capped so that multiple times interval stays at or below 32 s.
    function automatic logic [4:0] eff_mult(input logic [4:0] m, input logic [7:0] ivl);
        logic [15:0] prod;
        logic [15:0] fit;
        prod = 16'(m) * 16'(ivl);
        fit = 16'((gfs_pkg::REST_CAP - 16'h0001) / 16'(ivl));
        if (prod > gfs_pkg::REST_CAP) begin
            eff_mult = (fit == 16'h0000) ? gfs_pkg::MULT_MIN : 5'(fit);
        end else begin
            eff_mult = m;
        end
    endfunction : eff_mult

    function automatic gfs_pkg::gfs_settings_type defaults();
        defaults.interval = gfs_pkg::IVL_DEF;
        defaults.rest_mult = gfs_pkg::MULT_DEF;
        defaults.discharge_current_threshold = gfs_pkg::ITH_DEF;
        defaults.charge_current_threshold = gfs_pkg::ITH_DEF;
        defaults.max_soc_slope = gfs_pkg::SOC_DEF;
    endfunction : defaults

    // -------------------------------------------------------------------------
    // Next state.
    // -------------------------------------------------------------------------
    always_comb begin
        logic tick;
        logic bound;
        logic run;
        logic edit_ok;
        logic [gfs_pkg::NUM_EV-1:0] ev;
        tick = 1'b0;
        bound = 1'b0;
        run = 1'b0;
        edit_ok = 1'b0;
        ev = '0;
        s_nxt = s_r;
        s_nxt.iter_start = 1'b0;
        s_nxt.rest_heavy = 1'b0;
        s_nxt.alg_rst = 1'b0;
        s_nxt.rdata = 16'h0000;

        // Tenth-second tick and iteration boundary.
        if (s_r.tick_cnt >= TICK_LAST) begin
            s_nxt.tick_cnt = '0;
            tick = 1'b1;
        end else begin
            s_nxt.tick_cnt = s_r.tick_cnt + 1'b1;
        end
        if (tick) begin
            if (s_r.ivl_cnt + 8'h01 >= s_r.set.interval) begin
                s_nxt.ivl_cnt = 8'h00;
                bound = 1'b1;
            end else begin
                s_nxt.ivl_cnt = s_r.ivl_cnt + 8'h01;
            end
        end

        // Iteration end from the gauge core.
        if (GAUGE_DONE && s_r.flags[gfs_pkg::F_CALC]) begin
            s_nxt.flags[gfs_pkg::F_CALC] = 1'b0;
            ev[gfs_pkg::E_DONE] = 1'b1;
            if (s_r.flags[gfs_pkg::F_LOGC]) begin
                s_nxt.flags[gfs_pkg::F_LOGC] = 1'b0;
                ev[gfs_pkg::E_LOG] = 1'b1;
            end
        end

        // Queued actions are taken at a boundary between iterations.
        if (bound && !s_r.flags[gfs_pkg::F_CALC]) begin
            run = !s_r.flags[gfs_pkg::F_CFG] || s_r.flags[gfs_pkg::F_EXIT];
            if (s_r.flags[gfs_pkg::F_EXIT]) begin
                s_nxt.flags[gfs_pkg::F_CFG] = 1'b0;
                s_nxt.flags[gfs_pkg::F_EXIT] = 1'b0;
                ev[gfs_pkg::E_EXIT] = 1'b1;
            end
            if (s_r.flags[gfs_pkg::F_CRST]) begin
                s_nxt.set = defaults();
                s_nxt.flags[gfs_pkg::F_CRST] = 1'b0;
            end
            if (run) begin
                s_nxt.iter_start = 1'b1;
                s_nxt.flags[gfs_pkg::F_CALC] = 1'b1;
                if (s_r.flags[gfs_pkg::F_ARST]) begin
                    s_nxt.alg_rst = 1'b1;
                    s_nxt.flags[gfs_pkg::F_ARST] = 1'b0;
                end
                if (s_r.flags[gfs_pkg::F_LOGP]) begin
                    s_nxt.flags[gfs_pkg::F_LOGC] = 1'b1;
                    s_nxt.flags[gfs_pkg::F_LOGP] = 1'b0;
                end
                if (GAUGE_RESTING) begin
                    if (s_r.rest_cnt + 5'h01 >=
                        eff_mult(s_r.set.rest_mult, s_r.set.interval)) begin
                        s_nxt.rest_cnt = 5'h00;
                        s_nxt.rest_heavy = 1'b1;
                    end else begin
                        s_nxt.rest_cnt = s_r.rest_cnt + 5'h01;
                    end
                end else begin
                    s_nxt.rest_cnt = 5'h00;
                end
            end
        end

        // Settings take writes only in configuration state or between iterations.
        edit_ok = s_r.flags[gfs_pkg::F_CFG] || !s_r.flags[gfs_pkg::F_CALC];
        s_nxt.irq_st = s_r.irq_st;

        // Register writes; a write to the flag word has no effect.
        if (REG_WR) begin
            unique case (REG_ADDR)
                gfs_pkg::ADDR_CTRL: begin
                    if (REG_WDATA[gfs_pkg::C_ENTER]) begin
                        s_nxt.flags[gfs_pkg::F_CFG] = 1'b1;
                    end
                    if (REG_WDATA[gfs_pkg::C_EXIT] && s_nxt.flags[gfs_pkg::F_CFG]) begin
                        s_nxt.flags[gfs_pkg::F_EXIT] = 1'b1;
                    end
                    if (REG_WDATA[gfs_pkg::C_CRST]) begin
                        s_nxt.flags[gfs_pkg::F_CRST] = 1'b1;
                    end
                    if (REG_WDATA[gfs_pkg::C_ARST]) begin
                        s_nxt.flags[gfs_pkg::F_ARST] = 1'b1;
                    end
                    if (REG_WDATA[gfs_pkg::C_LOG]) begin
                        s_nxt.flags[gfs_pkg::F_LOGP] = 1'b1;
                    end
                    s_nxt.flags[gfs_pkg::F_BKUP] = REG_WDATA[gfs_pkg::C_BKUP];
                end
                gfs_pkg::ADDR_IRQ_CLR: begin
                    s_nxt.irq_st = s_r.irq_st & ~REG_WDATA[gfs_pkg::NUM_EV-1:0];
                end
                gfs_pkg::ADDR_IRQ_EN: begin
                    s_nxt.irq_en = REG_WDATA[gfs_pkg::NUM_EV-1:0];
                end
                gfs_pkg::ADDR_INTERVAL: begin
                    if (edit_ok) begin
                        s_nxt.set.interval = 8'(clamp(16'(REG_WDATA[7:0]),
                            16'(gfs_pkg::IVL_MIN), 16'(gfs_pkg::IVL_MAX)));
                        s_nxt.ivl_cnt = 8'h00;
                    end
                end
                gfs_pkg::ADDR_REST_MULT: begin
                    if (edit_ok) begin
                        s_nxt.set.rest_mult = 5'(clamp(16'(REG_WDATA[4:0]),
                            16'(gfs_pkg::MULT_MIN), 16'(gfs_pkg::MULT_MAX)));
                        s_nxt.rest_cnt = 5'h00;
                    end
                end
                gfs_pkg::ADDR_DISCHARGE_CURRENT_THRESHOLD: begin
                    if (edit_ok) begin
                        s_nxt.set.discharge_current_threshold = REG_WDATA;
                    end
                end
                gfs_pkg::ADDR_CHARGE_CURRENT_THRESHOLD: begin
                    if (edit_ok) begin
                        s_nxt.set.charge_current_threshold = REG_WDATA;
                    end
                end
                gfs_pkg::ADDR_MAX_SOC_SLOPE: begin
                    if (edit_ok) begin
                        s_nxt.set.max_soc_slope = clamp(REG_WDATA,
                            gfs_pkg::SOC_MIN, gfs_pkg::SOC_MAX);
                    end
                end
                default: begin
                end
            endcase
        end

        // Events win over a clear in the same cycle.
        s_nxt.irq_st = s_nxt.irq_st | ev;
        s_nxt.irq = |(s_nxt.irq_st & s_nxt.irq_en);
        s_nxt.flags[gfs_pkg::F_LIVE] = !s_nxt.flags[gfs_pkg::F_CALC];

        // Register reads; unmapped offsets read zero.
        if (REG_RD) begin
            unique case (REG_ADDR)
                gfs_pkg::ADDR_FLAGS: s_nxt.rdata = s_r.flags;
                gfs_pkg::ADDR_CTRL: s_nxt.rdata =
                    16'(s_r.flags[gfs_pkg::F_BKUP]) << gfs_pkg::C_BKUP;
                gfs_pkg::ADDR_IRQ_STAT: s_nxt.rdata = 16'(s_r.irq_st);
                gfs_pkg::ADDR_IRQ_EN: s_nxt.rdata = 16'(s_r.irq_en);
                gfs_pkg::ADDR_INTERVAL: s_nxt.rdata = 16'(s_r.set.interval);
                gfs_pkg::ADDR_REST_MULT: s_nxt.rdata = 16'(s_r.set.rest_mult);
                gfs_pkg::ADDR_DISCHARGE_CURRENT_THRESHOLD: s_nxt.rdata = s_r.set.discharge_current_threshold;
                gfs_pkg::ADDR_CHARGE_CURRENT_THRESHOLD: s_nxt.rdata = s_r.set.charge_current_threshold;
                gfs_pkg::ADDR_MAX_SOC_SLOPE: s_nxt.rdata = s_r.set.max_soc_slope;
                default: s_nxt.rdata = 16'h0000;
            endcase
        end
    end

    // -------------------------------------------------------------------------
    // State register.
    // -------------------------------------------------------------------------
    always_ff @(posedge SYS_CLK) begin
        if (!RSTN) begin
            s_r <= '0;
            s_r.set <= defaults();
        end else begin
            s_r <= s_nxt;
        end
    end

    assign REG_RDATA = s_r.rdata;
    assign ITER_START = s_r.iter_start;
    assign REST_HEAVY = s_r.rest_heavy;
    assign ALG_RESET = s_r.alg_rst;
    assign LOG_CLEARING = s_r.flags[gfs_pkg::F_LOGC];
    assign CONFIG_MODE = s_r.flags[gfs_pkg::F_CFG];
    assign LEARN_BKUP_MODE = s_r.flags[gfs_pkg::F_BKUP];
    assign SETTINGS = s_r.set;
    assign IRQ = s_r.irq;

    // -------------------------------------------------------------------------
    // Assertions.
    // -------------------------------------------------------------------------
    default clocking cb @(posedge SYS_CLK); endclocking
    default disable iff (!RSTN);

    property p_calc_end;
        GAUGE_DONE |=> !s_r.flags[gfs_pkg::F_CALC];
    endproperty
    a_calc_end: assert property (p_calc_end) else $error("calc flag stuck after done");

    property p_calc_start;
        ITER_START |-> s_r.flags[gfs_pkg::F_CALC] && $past(!s_r.flags[gfs_pkg::F_CALC]);
    endproperty
    a_calc_start: assert property (p_calc_start) else $error("calc flag not set");

    property p_live;
        $fell(s_r.flags[gfs_pkg::F_CALC]) |-> s_r.flags[gfs_pkg::F_LIVE];
    endproperty
    a_live: assert property (p_live) else $error("live edit flag wrong");

    property p_enter;
        REG_WR && REG_ADDR == gfs_pkg::ADDR_CTRL && REG_WDATA[gfs_pkg::C_ENTER]
            |=> CONFIG_MODE;
    endproperty
    a_enter: assert property (p_enter) else $error("config mode not entered");

    property p_exit;
        $fell(s_r.flags[gfs_pkg::F_EXIT]) |-> !CONFIG_MODE;
    endproperty
    a_exit: assert property (p_exit) else $error("exit done but still configuring");

    property p_crst;
        $fell(s_r.flags[gfs_pkg::F_CRST]) |-> SETTINGS.interval == gfs_pkg::IVL_DEF
            && SETTINGS.max_soc_slope == gfs_pkg::SOC_DEF;
    endproperty
    a_crst: assert property (p_crst) else $error("defaults not restored");

    property p_arst;
        ALG_RESET |-> $past(s_r.flags[gfs_pkg::F_ARST]) && !s_r.flags[gfs_pkg::F_ARST];
    endproperty
    a_arst: assert property (p_arst) else $error("algorithm reset without request");

    property p_logc;
        $rose(LOG_CLEARING) |-> ITER_START && $past(s_r.flags[gfs_pkg::F_LOGP]);
    endproperty
    a_logc: assert property (p_logc) else $error("log clear outside an iteration");

    property p_bkup;
        REG_WR && REG_ADDR == gfs_pkg::ADDR_CTRL
            |=> LEARN_BKUP_MODE == $past(REG_WDATA[gfs_pkg::C_BKUP]);
    endproperty
    a_bkup: assert property (p_bkup) else $error("backup mode not following control");

    property p_limits;
        SETTINGS.interval >= gfs_pkg::IVL_MIN && SETTINGS.interval <= gfs_pkg::IVL_MAX
            && SETTINGS.rest_mult >= gfs_pkg::MULT_MIN
            && SETTINGS.rest_mult <= gfs_pkg::MULT_MAX
            && SETTINGS.max_soc_slope <= gfs_pkg::SOC_MAX;
    endproperty
    a_limits: assert property (p_limits) else $error("setting out of range");

    property p_rest_cap;
        REST_HEAVY |-> 16'(s_r.rest_cnt) == 16'h0000
            && 16'(eff_mult(SETTINGS.rest_mult, SETTINGS.interval)) * 16'(SETTINGS.interval)
               <= gfs_pkg::REST_CAP;
    endproperty
    a_rest_cap: assert property (p_rest_cap) else $error("rest period above cap");

    property p_flag_rsvd;
        s_r.flags[15:12] == 4'h0 && s_r.flags[10:8] == 3'h0;
    endproperty
    a_flag_rsvd: assert property (p_flag_rsvd) else $error("reserved flag bit set");

    c_iter: cover property (ITER_START ##[1:16] GAUGE_DONE);
    c_rest: cover property (REST_HEAVY);
    c_log: cover property ($fell(LOG_CLEARING));
    c_irq: cover property ($rose(IRQ));

endmodule : gfs_regs

`default_nettype wire

// File: hw/gfs_pkg.sv
//------------------------------------------------------------------------------
// Summary of operation
//------------------------------------------------------------------------------
// Summary of operation
// - Flag bit 0 is high while a gauge iteration runs, low once done.
// - Flag bit 1 shows whether settings may be edited while the gauge runs.
// - Flag bit 2 is high in configuration state, low in normal running.
// - Flag bit 3 is high while a configuration exit is requested but pending.
// - Flag bit 4 is high while a restore of factory settings is queued.
// - Flag bit 5 shows whether an algorithm reset is queued.
// - Flag bit 6 is high during the iteration that clears the lifetime log.
// - Flag bit 7 is high while a lifetime log clear is requested, not done.
// - Flag bit 11 shows backup mode; backup writes are allowed only then.
// - Iteration interval is 8 bits in 0.1 s steps, default 4 s, 0.5-16 s.
// - At rest, heavy functions run every multiplier times the interval.
// - A rest period above 32 s falls back to the largest interval multiple below.
// - Discharge threshold is 16 bits in 1 mA steps, default 25 mA.
// - Charge threshold is 16 bits in 1 mA steps, default 25 mA.
// - Maximum SOC slope is 16 bits in 0.00005 %/s steps, default 0.07 %/s.
`default_nettype none

package gfs_pkg;

    // -------------------------------------------------------------------------
    // Register offsets.
    // -------------------------------------------------------------------------
    localparam logic [15:0] ADDR_FLAGS = 16'h0F00;
    localparam logic [15:0] ADDR_CTRL = 16'h0F02;
    localparam logic [15:0] ADDR_IRQ_STAT = 16'h0F10;
    localparam logic [15:0] ADDR_IRQ_CLR = 16'h0F12;
    localparam logic [15:0] ADDR_IRQ_EN = 16'h0F14;
    localparam logic [15:0] ADDR_INTERVAL = 16'h1000;
    localparam logic [15:0] ADDR_REST_MULT = 16'h1001;
    localparam logic [15:0] ADDR_DISCHARGE_CURRENT_THRESHOLD = 16'h1002;
    localparam logic [15:0] ADDR_CHARGE_CURRENT_THRESHOLD = 16'h1004;
    localparam logic [15:0] ADDR_MAX_SOC_SLOPE = 16'h1006;

    // -------------------------------------------------------------------------
    // Flag word bit positions.
    // -------------------------------------------------------------------------
    localparam int F_CALC = 0;
    localparam int F_LIVE = 1;
    localparam int F_CFG = 2;
    localparam int F_EXIT = 3;
    localparam int F_CRST = 4;
    localparam int F_ARST = 5;
    localparam int F_LOGC = 6;
    localparam int F_LOGP = 7;
    localparam int F_BKUP = 11;

    // -------------------------------------------------------------------------
    // Control register bits and interrupt event bits.
    // -------------------------------------------------------------------------
    localparam int C_ENTER = 0;
    localparam int C_EXIT = 1;
    localparam int C_CRST = 2;
    localparam int C_ARST = 3;
    localparam int C_LOG = 4;
    localparam int C_BKUP = 5;
    localparam int E_DONE = 0;
    localparam int E_EXIT = 1;
    localparam int E_LOG = 2;
    localparam int NUM_EV = 3;

    // -------------------------------------------------------------------------
    // Setting defaults and limits.
    // -------------------------------------------------------------------------
    localparam logic [7:0] IVL_DEF = 8'h28;
    localparam logic [7:0] IVL_MIN = 8'h05;
    localparam logic [7:0] IVL_MAX = 8'hA0;
    localparam logic [4:0] MULT_DEF = 5'h04;
    localparam logic [4:0] MULT_MIN = 5'h01;
    localparam logic [4:0] MULT_MAX = 5'h10;
    localparam logic [15:0] ITH_DEF = 16'h0019;
    localparam logic [15:0] SOC_DEF = 16'h0578;
    localparam logic [15:0] SOC_MIN = 16'h0001;
    localparam logic [15:0] SOC_MAX = 16'h9C40;
    localparam logic [15:0] REST_CAP = 16'h0140;

    // -------------------------------------------------------------------------
    // Timing.
    // -------------------------------------------------------------------------
    localparam int unsigned CLK_PERIOD_NS = 50;
    localparam int unsigned TICK_TIME_NS = 100000000;
    localparam int unsigned TICK_CYCLES = TICK_TIME_NS / CLK_PERIOD_NS;
    localparam int TICK_W = 24;

    typedef struct packed {
        logic [7:0] interval;
        logic [4:0] rest_mult;
        logic [15:0] discharge_current_threshold;
        logic [15:0] charge_current_threshold;
        logic [15:0] max_soc_slope;
    } gfs_settings_type;

endpackage : gfs_pkg

`default_nettype wire

// File: sim/gfs_gauge_model.sv
`default_nettype none

module gfs_gauge_model #(
    parameter int DONE_DELAY = 10
) (
    // Clock and reset.
    input wire logic sys_clk,
    input wire logic rstn,
    // Iteration handshake.
    input wire logic iter_start,
    output logic gauge_done
);
    timeunit 1ns;
    timeprecision 1ns;

    // -------------------------------------------------------------------------
    // Each iteration ends with a one-cycle done pulse after a fixed work time.
    // -------------------------------------------------------------------------
    int cnt;

    initial begin
        gauge_done = 1'b0;
        cnt = 0;
    end

    always @(posedge sys_clk) begin
        gauge_done <= 1'b0;
        if (!rstn) begin
            cnt <= 0;
        end else if (iter_start) begin
            cnt <= DONE_DELAY;
        end else if (cnt == 1) begin
            gauge_done <= 1'b1;
            cnt <= 0;
        end else if (cnt > 1) begin
            cnt <= cnt - 1;
        end
    end
endmodule : gfs_gauge_model

`default_nettype wire

// File: sim/gfs_regs_tb_top.sv
`default_nettype none

`define CHK(a, b) begin checked++; if ((a) !== (b)) begin err_total++; \
    $display("CHECK FAILED t=%0t got %h exp %h", $time, (a), (b)); end end

module gfs_regs_tb_top;
    timeunit 1ns;
    timeprecision 1ns;

    // -------------------------------------------------------------------------
    // Design under test and gauge core model.
    // -------------------------------------------------------------------------
    logic sys_clk = 1'b0;
    logic rstn = 1'b0;
    logic [15:0] addr = 16'h0000;
    logic [15:0] wdata = 16'h0000;
    logic wr = 1'b0;
    logic rd = 1'b0;
    logic resting = 1'b0;
    logic [15:0] rdata;
    logic done, iter_start, rest_heavy, alg_reset, log_clearing, cfg_mode, bkup, irq;
    gfs_pkg::gfs_settings_type settings;
    int err_total = 0;
    int checked = 0;
    logic [15:0] d;

    gfs_regs #(.TICK_CYCLES(4)) gfs_regs_i (.SYS_CLK(sys_clk), .RSTN(rstn),
        .REG_ADDR(addr), .REG_WDATA(wdata), .REG_WR(wr), .REG_RD(rd), .REG_RDATA(rdata),
        .GAUGE_DONE(done), .GAUGE_RESTING(resting), .ITER_START(iter_start),
        .REST_HEAVY(rest_heavy), .ALG_RESET(alg_reset), .LOG_CLEARING(log_clearing),
        .CONFIG_MODE(cfg_mode), .LEARN_BKUP_MODE(bkup), .SETTINGS(settings), .IRQ(irq));

    gfs_gauge_model gfs_gauge_model_i (.sys_clk(sys_clk), .rstn(rstn),
        .iter_start(iter_start), .gauge_done(done));

    initial begin
        forever #25 sys_clk = ~sys_clk;
    end

    // -------------------------------------------------------------------------
    // Register port and wait helpers.
    // -------------------------------------------------------------------------
    task automatic wr_reg(input logic [15:0] a, input logic [15:0] v);
        @(posedge sys_clk);
        wr <= 1'b1;
        addr <= a;
        wdata <= v;
        @(posedge sys_clk);
        wr <= 1'b0;
    endtask : wr_reg

    task automatic rd_reg(input logic [15:0] a, output logic [15:0] v);
        @(posedge sys_clk);
        rd <= 1'b1;
        addr <= a;
        @(posedge sys_clk);
        rd <= 1'b0;
        #1;
        v = rdata;
    endtask : rd_reg

    task automatic wait_for(input int sel, input int lim);
        logic hit;
        hit = 1'b0;
        for (int i = 0; i < lim && !hit; i++) begin
            @(posedge sys_clk);
            #1;
            hit = (sel == 0) ? (iter_start === 1'b1) :
                  (sel == 1) ? (cfg_mode === 1'b1) : (rest_heavy === 1'b1);
        end
        `CHK(hit, 1'b1)
    endtask : wait_for

    task automatic idle(input int n);
        repeat (n) @(posedge sys_clk);
        #1;
    endtask : idle

    // -------------------------------------------------------------------------
    // Scenarios.
    // -------------------------------------------------------------------------
    task automatic t_reset();
        rd_reg(gfs_pkg::ADDR_FLAGS, d); `CHK(d, 16'h0002)
        rd_reg(gfs_pkg::ADDR_INTERVAL, d); `CHK(d, 16'h0028)
        rd_reg(gfs_pkg::ADDR_REST_MULT, d); `CHK(d, 16'h0004)
        rd_reg(gfs_pkg::ADDR_DISCHARGE_CURRENT_THRESHOLD, d); `CHK(d, 16'h0019)
        rd_reg(gfs_pkg::ADDR_CHARGE_CURRENT_THRESHOLD, d); `CHK(d, 16'h0019)
        rd_reg(gfs_pkg::ADDR_MAX_SOC_SLOPE, d); `CHK(d, 16'h0578)
        idle(1); `CHK(rdata, 16'h0000)
        rd_reg(16'h0F20, d); `CHK(d, 16'h0000)
    endtask : t_reset

    task automatic t_config();
        wr_reg(gfs_pkg::ADDR_CTRL, 16'h0001);
        wait_for(1, 400);
        wr_reg(gfs_pkg::ADDR_INTERVAL, 16'h0001);
        rd_reg(gfs_pkg::ADDR_INTERVAL, d); `CHK(d, 16'h0005)
        wr_reg(gfs_pkg::ADDR_INTERVAL, 16'h00FF);
        wr_reg(gfs_pkg::ADDR_REST_MULT, 16'h001F);
        rd_reg(gfs_pkg::ADDR_REST_MULT, d); `CHK(d, 16'h0010)
        wr_reg(gfs_pkg::ADDR_REST_MULT, 16'h0000);
        wr_reg(gfs_pkg::ADDR_MAX_SOC_SLOPE, 16'hFFFF);
        wr_reg(gfs_pkg::ADDR_DISCHARGE_CURRENT_THRESHOLD, 16'h1234);
        wr_reg(gfs_pkg::ADDR_CHARGE_CURRENT_THRESHOLD, 16'hFFFF);
        wr_reg(gfs_pkg::ADDR_FLAGS, 16'hFFFF);
        `CHK(settings, {8'hA0, 5'h01, 16'h1234, 16'hFFFF, 16'h9C40})
        rd_reg(gfs_pkg::ADDR_FLAGS, d); `CHK(d, 16'h0006)
    endtask : t_config

    task automatic t_exit();
        wr_reg(gfs_pkg::ADDR_INTERVAL, 16'h0005);
        wr_reg(gfs_pkg::ADDR_CTRL, 16'h0006);
        rd_reg(gfs_pkg::ADDR_FLAGS, d); `CHK(d[4:2], 3'b111)
        wait_for(0, 400);
        `CHK(settings, {8'h28, 5'h04, 16'h0019, 16'h0019, 16'h0578})
        `CHK(cfg_mode, 1'b0)
        rd_reg(gfs_pkg::ADDR_FLAGS, d); `CHK(d, 16'h0001)
        idle(20);
        rd_reg(gfs_pkg::ADDR_FLAGS, d); `CHK(d, 16'h0002)
        wr_reg(gfs_pkg::ADDR_IRQ_EN, 16'h0001);
        idle(1); `CHK(irq, 1'b1)
        rd_reg(gfs_pkg::ADDR_IRQ_STAT, d); `CHK(d[1:0], 2'b11)
        wr_reg(gfs_pkg::ADDR_IRQ_CLR, 16'h0007);
        idle(1); `CHK(irq, 1'b0)
        wr_reg(gfs_pkg::ADDR_IRQ_EN, 16'h0000);
        wait_for(0, 400);
        idle(20); `CHK(irq, 1'b0)
        rd_reg(gfs_pkg::ADDR_IRQ_STAT, d); `CHK(d[0], 1'b1)
    endtask : t_exit

    task automatic t_queue();
        wr_reg(gfs_pkg::ADDR_CTRL, 16'h0038);
        rd_reg(gfs_pkg::ADDR_FLAGS, d);
        `CHK({d[11], d[7], d[5]}, 3'b111)
        `CHK(bkup, 1'b1)
        wait_for(0, 400);
        `CHK(alg_reset, 1'b1)
        rd_reg(gfs_pkg::ADDR_FLAGS, d); `CHK(d[7:5], 3'b010)
        `CHK(log_clearing, 1'b1)
        wr_reg(gfs_pkg::ADDR_DISCHARGE_CURRENT_THRESHOLD, 16'h0055);
        idle(0); `CHK(settings.discharge_current_threshold, 16'h0019)
        idle(20); `CHK(log_clearing, 1'b0)
        wr_reg(gfs_pkg::ADDR_DISCHARGE_CURRENT_THRESHOLD, 16'h0055);
        idle(0); `CHK(settings.discharge_current_threshold, 16'h0055)
        wr_reg(gfs_pkg::ADDR_CTRL, 16'h0000);
        rd_reg(gfs_pkg::ADDR_FLAGS, d); `CHK(d[11], 1'b0)
    endtask : t_queue

    task automatic t_rest();
        int n;
        wr_reg(gfs_pkg::ADDR_CTRL, 16'h0001);
        wait_for(1, 400);
        wr_reg(gfs_pkg::ADDR_REST_MULT, 16'h0010);
        wr_reg(gfs_pkg::ADDR_CTRL, 16'h0002);
        resting <= 1'b1;
        wait_for(2, 4000);
        n = 0;
        do begin
            wait_for(0, 400);
            n++;
        end while (rest_heavy !== 1'b1 && n < 20);
        `CHK(n, 7)
        wr_reg(gfs_pkg::ADDR_CTRL, 16'h0001);
        wait_for(1, 400);
        wr_reg(gfs_pkg::ADDR_INTERVAL, 16'h0005);
        wr_reg(gfs_pkg::ADDR_CTRL, 16'h0002);
        wait_for(2, 4000);
        n = 0;
        do begin
            wait_for(0, 400);
            n++;
        end while (rest_heavy !== 1'b1 && n < 20);
        `CHK(n, 16)
    endtask : t_rest

    // -------------------------------------------------------------------------
    // Verdict, watchdog and main sequence.
    // -------------------------------------------------------------------------
    task automatic print_verdict();
        $display("Comparisons %0d, mismatches %0d", checked, err_total);
        if (err_total == 0 && checked > 0) begin
            $display("Test passed");
        end else begin
            $display("Test failed");
        end
        $finish;
    endtask : print_verdict

    initial begin
        #(50 * 30000);
        err_total++;
        print_verdict();
    end

    initial begin
        repeat (2) @(posedge sys_clk);
        rstn <= 1'b1;
        t_reset();
        t_config();
        t_exit();
        t_queue();
        t_rest();
        print_verdict();
    end
endmodule : gfs_regs_tb_top

`default_nettype wire
